// >>> ipr_dev.sv
`timescale 1ns/1ns
// Behaviour
// - four quantities in sequence, all eight modes
// - total time follows per-mode schedule
// - stack sum stored in group A
// - stack sum code weight 30 x 100uV
// - die temperature code stored in group A
// - analog in A, digital in B
// - host sets path 0 or 1 first
// - redundant variant takes identical time
// - three primary engines plus one redundant
// - plain command never applies redundancy
// - stream feeds both engines, compared at end
// - mismatch stores fault word 0xff0x
// - low nibble flags mismatching result nibbles
// - fault word low bits never zero
// - one redundant converter, chosen automatically
// - path field leaves redundant converter fixed
// - forced fault makes comparison fail
// - path values 10 and 11 drop the check
module ipr_dev #(
    parameter int unsigned CYC_PER_US = ipr_pkg::IPR_CYC_PER_US
) (
    // clock and reset
    input  wire logic       clk_sys_in,
    input  wire logic       rst_n_in,
    // link to the host
    ipr_if.dev              link,
    // modulator bit streams, one per converter, same clock
    input  wire logic [2:0] mod_bits_in,
    // conversion status to local logic
    output logic            fault_out     // last slot held a fault word
);
    ////////////////////////////////////////////////////////////////////
    // declarations
    ipr_pkg::ipr_dev_state_type state_q;  // sequencer state
    ipr_pkg::ipr_dev_state_type state_d;
    logic [2:0]  ph_q;                    // slot 0..3, 4 = tail
    logic [2:0]  ph_d;
    logic [31:0] cnt_q;                   // cycles spent in slot
    logic [31:0] cnt_d;
    logic [2:0]  mode_q;                  // latched speed mode
    logic [2:0]  mode_d;
    logic        red_q;                   // redundancy in force
    logic        red_d;
    logic [1:0]  sel_q;                   // converter under check
    logic [1:0]  sel_d;
    logic [15:0] res_q [4];               // status groups
    logic [15:0] res_d [4];
    logic        fault_q;
    logic        fault_d;
    logic        start;                   // either command taken
    logic        ph_end;                  // last cycle of a slot
    logic [31:0] dur;                     // slot length in cycles
    logic        filt_clr;                // window restart
    logic [15:0] pri_res [3];             // primary engine results
    logic [15:0] red_res;                 // redundant engine result
    logic [15:0] cmp_res;                 // primary result under check
    logic [15:0] diff;                    // bitwise disagreement
    logic [3:0]  nib;                     // per-nibble disagreement
    logic [15:0] store_val;               // value written to a slot

    ////////////////////////////////////////////////////////////////////
    // slot timing; a slot runs from the previous end time to its own,
    // so the slot lengths add up exactly to the scheduled total
    // per-mode schedule
    always_comb begin
        int unsigned lo;
        int unsigned hi;
        lo = 0;
        hi = ipr_pkg::IPR_T_US[mode_q][ph_q];
        if (ph_q != 3'h0) begin
            lo = ipr_pkg::IPR_T_US[mode_q][ph_q - 3'h1];
        end
        dur = 32'((hi - lo) * CYC_PER_US);
    end

    // commands only taken while idle; a strobe while busy is dropped
    assign start  = (state_q == ipr_pkg::IPR_D_IDLE) &&
                    (link.measure_internal_params_cmd ||
                     link.measure_internal_params_redundant_cmd);
    assign ph_end = (state_q == ipr_pkg::IPR_D_RUN) &&
                    (cnt_q == dur - 32'h1);
    // each quantity gets a fresh window
    assign filt_clr = start || (ph_end && ph_q < 3'h4);

    ////////////////////////////////////////////////////////////////////
    // engines: one per converter, plus the single redundant one
    // three primary engines
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_pri
            ipr_filt u_filt (
                .clk_sys_in (clk_sys_in),
                .rst_n_in   (rst_n_in),
                .clr_in     (filt_clr),
                .en_in      (state_q == ipr_pkg::IPR_D_RUN),
                .bit_in     (mod_bits_in[g]),
                .res_out    (pri_res[g])
            );
        end
    endgenerate

    ipr_filt u_red (
        .clk_sys_in (clk_sys_in),
        .rst_n_in   (rst_n_in),
        .clr_in     (filt_clr),
        .en_in      ((state_q == ipr_pkg::IPR_D_RUN) && red_q),
        .bit_in     (mod_bits_in[sel_q]),
        .res_out    (red_res)
    );

    ////////////////////////////////////////////////////////////////////
    // comparison and fault word
    always_comb begin
        cmp_res = pri_res[sel_q];
        diff    = cmp_res ^ red_res;
        if (link.force_redundancy_fail) begin
            diff[0] = ~diff[0];
        end
    end

    generate
        for (g = 0; g < 4; g++) begin : g_nib
            assign nib[g] = |diff[4*g +: 4];
        end
    endgenerate

    // internal quantities always convert on converter 1
    // fault word replaces result
    // fault only when some nibble differs
    always_comb begin
        store_val = pri_res[0];
        if (red_q && (nib != 4'h0)) begin
            store_val = {ipr_pkg::IPR_FAULT_TOP, nib};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sequencer next state
    always_comb begin
        state_d = state_q;
        ph_d    = ph_q;
        cnt_d   = cnt_q;
        mode_d  = mode_q;
        red_d   = red_q;
        sel_d   = sel_q;
        case (state_q)
            ipr_pkg::IPR_D_IDLE: begin
                if (start) begin
                    state_d = ipr_pkg::IPR_D_RUN;
                    ph_d    = 3'h0;
                    cnt_d   = 32'h0;
                    mode_d  = link.cmd_mode;
                    red_d   = link.measure_internal_params_redundant_cmd &&
                              !link.redundancy_path_select[1];
                    // auto choice lands on converter 1
                    // values 10 and 11 leave no check here
                    sel_d   = 2'h0;
                end
            end
            ipr_pkg::IPR_D_RUN: begin
                if (ph_end) begin
                    cnt_d = 32'h0;
                    ph_d  = ph_q + 3'h1;
                    if (ph_q == 3'h4) begin
                        state_d = ipr_pkg::IPR_D_IDLE;
                        red_d   = 1'b0;
                    end
                end else begin
                    cnt_d = cnt_q + 32'h1;
                end
            end
            default: begin
                state_d = ipr_pkg::IPR_D_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            state_q <= ipr_pkg::IPR_D_IDLE;
            ph_q    <= 3'h0;
            cnt_q   <= 32'h0;
            mode_q  <= 3'h0;
            red_q   <= 1'b0;
            sel_q   <= 2'h0;
        end else begin
            state_q <= state_d;
            ph_q    <= ph_d;
            cnt_q   <= cnt_d;
            mode_q  <= mode_d;
            red_q   <= red_d;
            sel_q   <= sel_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // result slots: written at the end of their own conversion slot;
    // codes are raw, 100uV per count (stack sum scaled by 30)
    // sum, temperature, analog, digital order
    always_comb begin
        fault_d = fault_q;
        for (int i = 0; i < 4; i++) begin
            res_d[i] = res_q[i];
        end
        if (ph_end && ph_q < 3'h4) begin
            res_d[ph_q[1:0]] = store_val;
            fault_d          = red_q && (nib != 4'h0);
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            fault_q <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                res_q[i] <= ipr_pkg::IPR_RES_RST;
            end
        end else begin
            fault_q <= fault_d;
            for (int i = 0; i < 4; i++) begin
                res_q[i] <= res_d[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs
    // stack sum in group A
    // code kept unscaled for host math
    assign link.stack_sum_code      = res_q[ipr_pkg::IPR_P_SUM];
    assign link.die_temp_code       = res_q[ipr_pkg::IPR_P_TEMP];
    // analog in A, digital in B
    assign link.analog_supply_code  = res_q[ipr_pkg::IPR_P_ANA];
    assign link.digital_supply_code = res_q[ipr_pkg::IPR_P_DIG];
    assign link.busy                = (state_q == ipr_pkg::IPR_D_RUN);
    assign fault_out                = fault_q;
endmodule

// >>> ipr_pkg.sv
package ipr_pkg;

    ////////////////////////////////////////////////////////////////////
    // clock and time base
    localparam int unsigned IPR_CLK_NS     = 4;                 // period
    localparam int unsigned IPR_CYC_PER_US = 1000 / IPR_CLK_NS; // 250

    ////////////////////////////////////////////////////////////////////
    // sequence shape
    localparam int unsigned IPR_NUM_MODES  = 8;  // conversion speeds
    localparam int unsigned IPR_NUM_PARAMS = 4;  // converted quantities
    localparam int unsigned IPR_NUM_PH     = 5;  // four slots plus tail
    localparam int unsigned IPR_NUM_ADC    = 3;  // primary converters

    // slot order of the quantities
    localparam int unsigned IPR_P_SUM  = 0;      // stack sum
    localparam int unsigned IPR_P_TEMP = 1;      // die temperature
    localparam int unsigned IPR_P_ANA  = 2;      // analog supply
    localparam int unsigned IPR_P_DIG  = 3;      // digital supply

    // end times in us per mode: slot 1..4 ends, then total
    // modes 0..7 = 27k, 14k, 7k, 3k, 2k, 1k, 422, 26 Hz
    localparam int unsigned IPR_T_US [8][5] = '{
        '{58,    104,   151,   198,    742},
        '{87,    163,   238,   314,    858},
        '{145,   279,   413,   547,    1556},
        '{261,   512,   762,   1012,   2022},
        '{494,   977,   1460,  1943,   2953},
        '{960,   1908,  2857,  3805,   4814},
        '{1890,  3770,  5649,  7529,   8538},
        '{29818, 59624, 89431, 119238, 134211}
    };

    ////////////////////////////////////////////////////////////////////
    // result coding
    localparam logic [15:0] IPR_RES_MAX    = 16'hdfff; // largest valid
    localparam logic [11:0] IPR_FAULT_TOP  = 12'hff0;  // fault word top
    localparam logic [15:0] IPR_RES_RST    = 16'h0000; // reset value

    ////////////////////////////////////////////////////////////////////
    // controller registers (word addresses) and fields
    localparam logic [3:0] IPR_A_CTRL   = 4'h0;
    localparam logic [3:0] IPR_A_STAT   = 4'h1;
    localparam logic [3:0] IPR_A_IEN    = 4'h2;
    localparam logic [3:0] IPR_A_ICLR   = 4'h3;
    localparam logic [3:0] IPR_A_RES0   = 4'h4;  // results 4..7
    localparam int unsigned IPR_B_GO    = 0;
    localparam int unsigned IPR_B_RED   = 1;
    localparam int unsigned IPR_B_MODE  = 2;     // 3 bits
    localparam int unsigned IPR_B_PATH  = 5;     // 2 bits
    localparam int unsigned IPR_B_FORCE = 7;
    localparam int unsigned IPR_S_DONE  = 0;
    localparam int unsigned IPR_S_FAULT = 1;
    localparam logic [7:0]  IPR_CTRL_RST = 8'h00;
    localparam logic [1:0]  IPR_IRQ_RST  = 2'h0;

    ////////////////////////////////////////////////////////////////////
    // state machines
    typedef enum {IPR_D_IDLE, IPR_D_RUN} ipr_dev_state_type;
    typedef enum {IPR_H_IDLE, IPR_H_WAIT} ipr_host_state_type;

endpackage

// >>> ipr_if.sv
`timescale 1ns/1ns
interface ipr_if;
    // command strobes and configuration from the host
    logic        measure_internal_params_cmd;
    logic        measure_internal_params_redundant_cmd;
    logic [2:0]  cmd_mode;
    logic [1:0]  redundancy_path_select;
    logic        force_redundancy_fail;
    // device status and result groups
    logic        busy;
    logic [15:0] stack_sum_code;
    logic [15:0] die_temp_code;
    logic [15:0] analog_supply_code;
    logic [15:0] digital_supply_code;

    modport dev (
        input  measure_internal_params_cmd,
        input  measure_internal_params_redundant_cmd,
        input  cmd_mode,
        input  redundancy_path_select,
        input  force_redundancy_fail,
        output busy,
        output stack_sum_code,
        output die_temp_code,
        output analog_supply_code,
        output digital_supply_code
    );
    modport host (
        output measure_internal_params_cmd,
        output measure_internal_params_redundant_cmd,
        output cmd_mode,
        output redundancy_path_select,
        output force_redundancy_fail,
        input  busy,
        input  stack_sum_code,
        input  die_temp_code,
        input  analog_supply_code,
        input  digital_supply_code
    );
endinterface

// >>> ipr_filt.sv
`timescale 1ns/1ns
// integrate-and-differentiate engine: counts ones of the modulator
// stream between two clears, so the window difference is the count
module ipr_filt #(
    parameter int unsigned ACC_W = 32
) (
    // clock and reset
    input  wire logic        clk_sys_in,
    input  wire logic        rst_n_in,
    // stream control
    input  wire logic        clr_in,     // restart the window
    input  wire logic        en_in,      // integrate this cycle
    input  wire logic        bit_in,     // modulator bit
    // window result
    output logic [15:0]      res_out
);
    logic [ACC_W-1:0] acc_q;             // integrator
    logic [ACC_W-1:0] acc_d;

    ////////////////////////////////////////////////////////////////////
    // integrator next value; clearing drops the previous window
    always_comb begin
        acc_d = acc_q;
        if (clr_in) begin
            acc_d = '0;
        end else if (en_in && bit_in) begin
            acc_d = acc_q + ACC_W'(1);
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            acc_q <= '0;
        end else begin
            acc_q <= acc_d;
        end
    end

    // clip so a valid result never reaches the fault code range
    assign res_out = (acc_q > ACC_W'(ipr_pkg::IPR_RES_MAX)) ?
                     ipr_pkg::IPR_RES_MAX : acc_q[15:0];
endmodule

// >>> ipr_host.sv
`timescale 1ns/1ns
// host end: takes orders through a small register port, strobes the
// command, waits the full schedule, then captures the four codes
module ipr_host #(
    parameter int unsigned CYC_PER_US = ipr_pkg::IPR_CYC_PER_US
) (
    // clock and reset
    input  wire logic        clk_sys_in,
    input  wire logic        rst_n_in,
    // register port
    input  wire logic [3:0]  reg_addr_in,
    input  wire logic [15:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic [15:0]      reg_rdata_out,
    // interrupt
    output logic             irq_out,
    // link to the device
    ipr_if.host              link
);
    ipr_pkg::ipr_host_state_type state_q;  // wait state
    ipr_pkg::ipr_host_state_type state_d;
    logic [7:0]  cfg_q;                    // control fields
    logic [7:0]  cfg_d;
    logic        cmd_q;                    // command strobe
    logic        cmd_d;
    logic [31:0] cnt_q;                    // cycles since command
    logic [31:0] cnt_d;
    logic [15:0] res_q [4];                // captured codes
    logic [15:0] res_d [4];
    logic [1:0]  st_q;                     // sticky done, fault
    logic [1:0]  st_d;
    logic [1:0]  ien_q;                    // interrupt enables
    logic [1:0]  ien_d;
    logic [15:0] rd_q;                     // read data
    logic [15:0] rd_d;
    logic [1:0]  set;                      // events this cycle
    logic [31:0] total;                    // schedule total in cycles
    logic [15:0] live [4];                 // codes from the device

    assign live[0] = link.stack_sum_code;
    assign live[1] = link.die_temp_code;
    assign live[2] = link.analog_supply_code;
    assign live[3] = link.digital_supply_code;
    assign total = 32'(ipr_pkg::IPR_T_US[cfg_q[4:2]][4] * CYC_PER_US);

    ////////////////////////////////////////////////////////////////////
    // command and capture sequence
    always_comb begin
        state_d = state_q;
        cfg_d   = cfg_q;
        cmd_d   = 1'b0;
        cnt_d   = cnt_q;
        set     = 2'h0;
        for (int i = 0; i < 4; i++) begin
            res_d[i] = res_q[i];
        end
        // fields change only while idle, so a run sees stable config
        if (reg_wr_in && reg_addr_in == ipr_pkg::IPR_A_CTRL &&
            state_q == ipr_pkg::IPR_H_IDLE) begin
            cfg_d = {reg_wdata_in[7:1], 1'b0};
            if (reg_wdata_in[ipr_pkg::IPR_B_GO]) begin
                cmd_d   = 1'b1;
                cnt_d   = 32'h0;
                state_d = ipr_pkg::IPR_H_WAIT;
            end
        end
        case (state_q)
            ipr_pkg::IPR_H_IDLE: begin
            end
            ipr_pkg::IPR_H_WAIT: begin
                // read only after the schedule and idle device
                if (cnt_q >= total && !link.busy) begin
                    state_d = ipr_pkg::IPR_H_IDLE;
                    set[ipr_pkg::IPR_S_DONE] = 1'b1;
                    for (int i = 0; i < 4; i++) begin
                        res_d[i] = live[i];
                        if (live[i][15:4] == ipr_pkg::IPR_FAULT_TOP) begin
                            set[ipr_pkg::IPR_S_FAULT] = 1'b1;
                        end
                    end
                end else begin
                    cnt_d = cnt_q + 32'h1;
                end
            end
            default: begin
                state_d = ipr_pkg::IPR_H_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // status, enables and read port; a new event beats a clear
    always_comb begin
        st_d  = set | (st_q & ~((reg_wr_in &&
                 reg_addr_in == ipr_pkg::IPR_A_ICLR) ?
                 reg_wdata_in[1:0] : 2'h0));
        ien_d = ien_q;
        if (reg_wr_in && reg_addr_in == ipr_pkg::IPR_A_IEN) begin
            ien_d = reg_wdata_in[1:0];
        end
        rd_d = 16'h0000;
        if (reg_rd_in) begin
            case (reg_addr_in)
                ipr_pkg::IPR_A_CTRL: rd_d = {8'h00, cfg_q};
                ipr_pkg::IPR_A_STAT: rd_d = {14'h0000, st_q};
                ipr_pkg::IPR_A_IEN:  rd_d = {14'h0000, ien_q};
                4'h4, 4'h5, 4'h6, 4'h7: rd_d = res_q[reg_addr_in[1:0]];
                default:             rd_d = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            state_q <= ipr_pkg::IPR_H_IDLE;
            cfg_q   <= ipr_pkg::IPR_CTRL_RST;
            cmd_q   <= 1'b0;
            cnt_q   <= 32'h0;
            st_q    <= ipr_pkg::IPR_IRQ_RST;
            ien_q   <= ipr_pkg::IPR_IRQ_RST;
            rd_q    <= 16'h0000;
            for (int i = 0; i < 4; i++) begin
                res_q[i] <= ipr_pkg::IPR_RES_RST;
            end
        end else begin
            state_q <= state_d;
            cfg_q   <= cfg_d;
            cmd_q   <= cmd_d;
            cnt_q   <= cnt_d;
            st_q    <= st_d;
            ien_q   <= ien_d;
            rd_q    <= rd_d;
            for (int i = 0; i < 4; i++) begin
                res_q[i] <= res_d[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // link drive
    assign link.measure_internal_params_cmd =
        cmd_q && !cfg_q[ipr_pkg::IPR_B_RED];
    assign link.measure_internal_params_redundant_cmd =
        cmd_q && cfg_q[ipr_pkg::IPR_B_RED];
    assign link.cmd_mode = cfg_q[4:2];
    // redundant run forces path to 0 or 1
    assign link.redundancy_path_select =
        (cfg_q[ipr_pkg::IPR_B_RED] && cfg_q[6]) ? 2'h0 : cfg_q[6:5];
    assign link.force_redundancy_fail = cfg_q[ipr_pkg::IPR_B_FORCE];
    assign reg_rdata_out = rd_q;
    assign irq_out       = |(st_q & ien_q);
endmodule

// >>> ipr_asserts.sv
`timescale 1ns/1ns
// link watcher: sum, temperature and digital codes may move only at slot ends of the latched mode
module ipr_asserts #(
    parameter int unsigned CYC_PER_US = 1
) (
    // clock and reset
    input  wire logic        clk_sys_in,
    input  wire logic        rst_n_in,
    // link signals
    input  wire logic        measure_internal_params_cmd,
    input  wire logic        measure_internal_params_redundant_cmd,
    input  wire logic [2:0]  cmd_mode,
    input  wire logic [1:0]  redundancy_path_select,
    input  wire logic        busy,
    input  wire logic [15:0] stack_sum_code,
    input  wire logic [15:0] die_temp_code,
    input  wire logic [15:0] digital_supply_code
);
    ////////////////////////////////////////////////////////////////
    logic        take;           // command accepted this cycle
    logic [2:0]  mode_q, mode_d; // mode of the running command
    logic [31:0] cnt_q, cnt_d;   // busy cycles so far
    assign take = ~busy & (measure_internal_params_cmd
                  | measure_internal_params_redundant_cmd);
    // next values of the helpers
    always_comb begin
        mode_d = take ? cmd_mode : mode_q;
        cnt_d  = busy ? cnt_q + 32'h1 : 32'h0;
    end
    // helper registers
    always_ff @(posedge clk_sys_in) begin
        mode_q <= rst_n_in ? mode_d : 3'h0;
        cnt_q  <= rst_n_in ? cnt_d : 32'h0;
    end
    // end of slot k in cycles
    function automatic int ends(logic [2:0] m, int k);
        return ipr_pkg::IPR_T_US[m][k] * CYC_PER_US;
    endfunction
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    // one cycle of slack, since the write edge is the designer's choice
    property p_slot(logic [15:0] c, int k);
        $changed(c) |-> cnt_q + 1 >= ends(mode_q, k)
            && cnt_q <= ends(mode_q, k) + 1;
    endproperty
    property p_word(logic [15:0] c);
        c > ipr_pkg::IPR_RES_MAX |->
            c[15:4] == ipr_pkg::IPR_FAULT_TOP && c[3:0] != 4'h0;
    endproperty
    ////////////////////////////////////////////////////////////////
    a_busy_start: assert property (take |=> busy)
        else $error("command did not start a run");
    a_busy_len: assert property (
        $fell(busy) |-> cnt_q == ends(mode_q, 4))
        else $error("run length off schedule");
    a_path_legal: assert property (
        measure_internal_params_redundant_cmd
        |-> !redundancy_path_select[1])
        else $error("redundant command with pinned path");
    a_sum_slot: assert property (p_slot(stack_sum_code, 0))
        else $error("sum code moved off its slot end");
    a_temp_slot: assert property (p_slot(die_temp_code, 1))
        else $error("temperature code moved off its slot end");
    a_dig_slot: assert property (p_slot(digital_supply_code, 3))
        else $error("digital code moved off its slot end");
    a_sum_word: assert property (p_word(stack_sum_code))
        else $error("bad fault word in sum code");
    a_dig_word: assert property (p_word(digital_supply_code))
        else $error("bad fault word in digital code");
    c_red: cover property (take && measure_internal_params_redundant_cmd);
    c_fault: cover property (stack_sum_code == 16'hff01);
    c_done: cover property ($fell(busy));
endmodule

// >>> ipr_tb_top.sv
`timescale 1ns/1ns
// drives the host register port and the streams of the device end
module ipr_tb_top;
    localparam int unsigned CYC = 1; // shortens every schedule
    logic        clk_sys_in = 1'b0;
    logic        rst_n_in   = 1'b0;
    logic [3:0]  addr       = 4'h0;  // register port
    logic [15:0] wdata      = 16'h0000;
    logic        wr         = 1'b0;
    logic        rd_s       = 1'b0;
    logic [15:0] rdata;
    logic        irq;
    logic        fault;
    logic [2:0]  mod_bits   = 3'h0;  // converter 1 stays low
    logic [1:0]  ien        = 2'h0;  // model of the enable register
    int          seed       = 5272;
    int          mismatches = 0;
    int          cmp_count  = 0;
    int          cycles     = 0;
    int          m;
    always #2 clk_sys_in = ~clk_sys_in;
    ////////////////////////////////////////////////////////////////
    ipr_if i_ipr_if ();
    ipr_dev #(.CYC_PER_US(CYC)) i_ipr_dev (
        .clk_sys_in (clk_sys_in),
        .rst_n_in   (rst_n_in),
        .link       (i_ipr_if),
        .mod_bits_in(mod_bits),
        .fault_out  (fault));
    ipr_host #(.CYC_PER_US(CYC)) i_ipr_host (
        .clk_sys_in   (clk_sys_in),
        .rst_n_in     (rst_n_in),
        .reg_addr_in  (addr),
        .reg_wdata_in (wdata),
        .reg_wr_in    (wr),
        .reg_rd_in    (rd_s),
        .reg_rdata_out(rdata),
        .irq_out      (irq),
        .link         (i_ipr_if));
    ipr_asserts #(.CYC_PER_US(CYC)) i_ipr_asserts (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .measure_internal_params_cmd(i_ipr_if.measure_internal_params_cmd),
        .measure_internal_params_redundant_cmd(
            i_ipr_if.measure_internal_params_redundant_cmd),
        .cmd_mode(i_ipr_if.cmd_mode),
        .redundancy_path_select(i_ipr_if.redundancy_path_select),
        .busy(i_ipr_if.busy),
        .stack_sum_code(i_ipr_if.stack_sum_code),
        .die_temp_code(i_ipr_if.die_temp_code),
        .digital_supply_code(i_ipr_if.digital_supply_code));
    // noise on converters 2 and 3 must never reach the stored codes
    always @(posedge clk_sys_in) begin
        mod_bits[2:1] <= 2'($random(seed));
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            mismatches = mismatches + 1;
            end_of_test();
        end
    end
    ////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic wr_reg(logic [3:0] a, logic [15:0] d);
        @(posedge clk_sys_in);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk_sys_in);
        wr    <= 1'b0;
    endtask
    task automatic rd_reg(logic [3:0] a, logic [15:0] e);
        @(posedge clk_sys_in);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk_sys_in);
        rd_s <= 1'b0;
        #1;
        chk($sformatf("reg %0h", a), e, rdata);
    endtask
    // one command through the host; model: a forced redundant run
    // stores the nibble-0 fault word, anything else counts zero ones
    task automatic run(logic [2:0] md, logic red, logic frc,
                       logic [1:0] p);
        logic [7:0]  c;
        logic        f;
        int          n;
        c = {frc, p, md, red, 1'b1};
        f = red && frc;
        wr_reg(ipr_pkg::IPR_A_CTRL, {8'h00, c});
        wr_reg(ipr_pkg::IPR_A_CTRL, 16'h009b); // refused while waiting
        n = 0;
        while (i_ipr_if.busy !== 1'b0 && n < 40000) begin
            @(posedge clk_sys_in);
            n++;
        end
        repeat (4) @(posedge clk_sys_in);
        #1;
        chk("irq", {15'h0, |(ien & {f, 1'b1})}, {15'h0, irq});
        chk("fault", {15'h0, f}, {15'h0, fault});
        rd_reg(ipr_pkg::IPR_A_STAT, {14'h0, f, 1'b1});
        for (n = 0; n < 4; n++)
            rd_reg(ipr_pkg::IPR_A_RES0 + n[3:0], f ? 16'hff01 : 0);
        if (!p[1])
            rd_reg(ipr_pkg::IPR_A_CTRL, {8'h00, c & 8'hfe});
        wr_reg(ipr_pkg::IPR_A_ICLR, 16'h0003);
        rd_reg(ipr_pkg::IPR_A_STAT, 16'h0000);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        rd_reg(ipr_pkg::IPR_A_STAT, 16'h0000);
        rd_reg(4'h9, 16'h0000);
        ien = 2'h3;
        wr_reg(ipr_pkg::IPR_A_IEN, 16'h0003);
        rd_reg(ipr_pkg::IPR_A_IEN, 16'h0003);
        // slowest mode alone would outrun the cycle budget
        for (m = 0; m < 7; m++)
            run(m[2:0], m[0], 1'b1, m[2:1]);
        run(3'h0, 1'b1, 1'b1, 2'h3);
        run(3'h0, 1'b1, 1'b0, 2'h1);
        ien = 2'h0;
        wr_reg(ipr_pkg::IPR_A_IEN, 16'h0000);
        run(3'h2, 1'b0, 1'b0, 2'h0);
        end_of_test();
    end
endmodule
